// *** core/dsss_hdr_pkg.sv ***
package dsss_hdr_pkg;
	// clock and symbol timing
	localparam int CLK_HZ = 100_000_000;
	localparam int SYM_LO_HZ = 1_000_000;
	localparam int SYM_HI_HZ = 1_375_000;
	localparam int SYM_LO_CYC = (CLK_HZ + SYM_LO_HZ / 2) / SYM_LO_HZ;
	localparam int SYM_HI_CYC = (CLK_HZ + SYM_HI_HZ / 2) / SYM_HI_HZ;
	localparam int US_NS = 1000;
	localparam int CLK_NS = 10;
	localparam int US_CYC = US_NS / CLK_NS;
	// register byte offsets
	localparam logic [7:0] OFF_PREAMBLE_LENGTH = 8'h00;
	localparam logic [7:0] OFF_SEARCH_TIMEOUT = 8'h04;
	localparam logic [7:0] OFF_SIG_RATE1 = 8'h08;
	localparam logic [7:0] OFF_SIG_RATE2 = 8'h0C;
	localparam logic [7:0] OFF_SIG_RATE5_5 = 8'h10;
	localparam logic [7:0] OFF_SIG_RATE11 = 8'h14;
	localparam logic [7:0] OFF_TX_MOD_SEL = 8'h18;
	localparam logic [7:0] OFF_SERVICE = 8'h1C;
	localparam logic [7:0] OFF_TX_LENGTH = 8'h20;
	localparam logic [7:0] OFF_RX_STATUS = 8'h24;
	localparam logic [7:0] OFF_SCR_TAPS = 8'h28;
	localparam logic [7:0] OFF_TX_STATUS = 8'h2C;
	// reset values
	localparam logic [7:0] RST_PREAMBLE_LENGTH = 8'h80;
	localparam logic [7:0] RST_SEARCH_TIMEOUT = 8'h40;
	localparam logic [31:0] RST_SIG_CODES = 32'h6E37140A;
	localparam logic [7:0] RST_TX_MOD_SEL = 8'h00;
	localparam logic [7:0] RST_SERVICE = 8'h00;
	localparam logic [15:0] RST_TX_LENGTH = 16'h0000;
	localparam logic [6:0] RST_SCR_TAPS = 7'h48;
	// field positions
	localparam int MOD_LSB = 0;
	localparam int MOD_CCK_BIT = 2;
	localparam int RXS_SFD = 0;
	localparam int RXS_TIMEOUT = 1;
	localparam int RXS_CRC_ERR = 2;
	localparam int RXS_SIG_BAD = 3;
	localparam int RXS_RATE_LSB = 6;
	// modulation codes
	localparam logic [1:0] MOD_DBPSK = 2'h0;
	localparam logic [1:0] MOD_DQPSK = 2'h1;
	localparam logic [1:0] MOD_RATE5_5 = 2'h2;
	localparam logic [1:0] MOD_RATE11 = 2'h3;
	// framing constants
	localparam logic [15:0] SFD_VALUE = 16'hF3A0;
	localparam int SFD_BITS = 16;
	localparam int FIELD_BITS = 32;
	localparam int HDR_BITS = 48;
	localparam int CRC_BITS = 16;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [6:0] SCR_SEED = 7'h6C;
	// modified walsh words, index m at bits [8m+7:8m], chip k at bit k
	localparam logic [63:0] MWALSH = 64'h6A6559563F300C03;
endpackage

// *** core/crc16_serial.sv ***
`timescale 1ns/100ps
module crc16_serial (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// control
	input wire logic init,
	input wire logic en,
	input wire logic shift_out,
	input wire logic bit_in,
	// results
	output logic out_bit,
	output logic [15:0] crc
);
	logic fb;
	logic [15:0] crc_r;
	logic [15:0] crc_nxt;

	// divide by the generator; shift mode empties msb first
	assign fb = crc_r[15] ^ bit_in;
	assign crc_nxt = init ? dsss_hdr_pkg::CRC_PRESET :
		shift_out ? {crc_r[14:0], 1'b1} :
		en ? ({crc_r[14:0], 1'b0} ^ (fb ? dsss_hdr_pkg::CRC_POLY : 16'h0000)) :
		crc_r;
	assign out_bit = ~crc_r[15];
	assign crc = crc_r;

	// register preset to all ones
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			crc_r <= dsss_hdr_pkg::CRC_PRESET;
		else
			crc_r <= crc_nxt;
	end
endmodule

// *** core/dsss_phy_header_framer.sv ***
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/100ps
module dsss_phy_header_framer #(
	parameter int TAIL_SYMS = 3,
	parameter int ADR_W = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// payload from the mac
	input wire logic transmit_power_enable,
	input wire logic [7:0] tx_data,
	input wire logic tx_data_valid,
	input wire logic tx_data_last,
	output logic tx_data_ready,
	// symbols to the spreader
	output logic sym_strobe,
	output logic [15:0] chip_phase,
	output logic data_portion,
	output logic tx_busy,
	// demodulator side
	input wire logic receive_power_enable,
	input wire logic rx_pn_acquired,
	input wire logic rx_bit,
	input wire logic rx_bit_valid,
	output logic rx_reacquire,
	output logic demod_data_valid,
	output logic rx_rate_switch,
	output logic [1:0] rx_rate,
	output logic [15:0] rx_length
);
	if (TAIL_SYMS < 1 || TAIL_SYMS > 255 || ADR_W < 6)
		$error("unsupported parameter value");

	typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_HDR, TX_CRC, TX_DATA,
		TX_TAIL, TX_DONE} tx_state_e;
	typedef enum logic [2:0] {RX_IDLE, RX_SEARCH, RX_HDR, RX_DATA,
		RX_LOST} rx_state_e;

	function automatic logic [7:0] sig_for(input logic [1:0] m,
		input logic [31:0] codes);
		sig_for = codes[8 * m +: 8];
	endfunction

	// scrambles n bits lsb first; returns {state, bits}
	function automatic logic [14:0] scramble(input logic [7:0] d,
		input logic [3:0] n, input logic [6:0] st, input logic [6:0] taps);
		logic [6:0] s;
		logic [7:0] o;
		logic b;
		s = st;
		o = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			if (4'(i) < n)
			begin
				b = d[i] ^ (^(s & taps));
				o[i] = b;
				s = {s[5:0], b};
			end
		end
		scramble = {s, o};
	endfunction

	// register file
	logic [7:0] pre_len_r, timeout_r, mod_sel_r, service_r;
	logic [31:0] sig_codes_r;
	logic [15:0] length_r;
	logic [6:0] taps_r;
	logic [7:0] rx_status_r;
	logic underrun_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic [31:0] rd_word;
	logic [7:0] adr;
	logic wr_en;

	assign adr = 8'({wb_adr_i[ADR_W-1:2], 2'b00});
	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// read mux; unmapped words read zero and still ack
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (adr)
			dsss_hdr_pkg::OFF_PREAMBLE_LENGTH: rd_word[7:0] = pre_len_r;
			dsss_hdr_pkg::OFF_SEARCH_TIMEOUT: rd_word[7:0] = timeout_r;
			dsss_hdr_pkg::OFF_SIG_RATE1: rd_word[7:0] = sig_codes_r[7:0];
			dsss_hdr_pkg::OFF_SIG_RATE2: rd_word[7:0] = sig_codes_r[15:8];
			dsss_hdr_pkg::OFF_SIG_RATE5_5: rd_word[7:0] = sig_codes_r[23:16];
			dsss_hdr_pkg::OFF_SIG_RATE11: rd_word[7:0] = sig_codes_r[31:24];
			dsss_hdr_pkg::OFF_TX_MOD_SEL: rd_word[7:0] = mod_sel_r;
			dsss_hdr_pkg::OFF_SERVICE: rd_word[7:0] = service_r;
			dsss_hdr_pkg::OFF_TX_LENGTH: rd_word[15:0] = length_r;
			dsss_hdr_pkg::OFF_RX_STATUS: rd_word[7:0] = rx_status_r;
			dsss_hdr_pkg::OFF_SCR_TAPS: rd_word[6:0] = taps_r;
			dsss_hdr_pkg::OFF_TX_STATUS: rd_word[1:0] = {underrun_r, tx_busy};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// one wait state; write lands on the edge that sees ack
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
			if (wb_cyc_i & wb_stb_i & ~ack_r)
				dat_r <= rd_word;
		end
	end

	// writable registers, byte lane 0 (length also lane 1)
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			pre_len_r <= dsss_hdr_pkg::RST_PREAMBLE_LENGTH;
			timeout_r <= dsss_hdr_pkg::RST_SEARCH_TIMEOUT;
			sig_codes_r <= dsss_hdr_pkg::RST_SIG_CODES;
			mod_sel_r <= dsss_hdr_pkg::RST_TX_MOD_SEL;
			service_r <= dsss_hdr_pkg::RST_SERVICE;
			length_r <= dsss_hdr_pkg::RST_TX_LENGTH;
			taps_r <= dsss_hdr_pkg::RST_SCR_TAPS;
		end
		else if (wr_en)
		begin
			if (wb_sel_i[0])
				case (adr)
					dsss_hdr_pkg::OFF_PREAMBLE_LENGTH: pre_len_r <= wb_dat_i[7:0];
					dsss_hdr_pkg::OFF_SEARCH_TIMEOUT: timeout_r <= wb_dat_i[7:0];
					dsss_hdr_pkg::OFF_SIG_RATE1: sig_codes_r[7:0] <= wb_dat_i[7:0];
					dsss_hdr_pkg::OFF_SIG_RATE2: sig_codes_r[15:8] <= wb_dat_i[7:0];
					dsss_hdr_pkg::OFF_SIG_RATE5_5: sig_codes_r[23:16] <= wb_dat_i[7:0];
					dsss_hdr_pkg::OFF_SIG_RATE11: sig_codes_r[31:24] <= wb_dat_i[7:0];
					dsss_hdr_pkg::OFF_TX_MOD_SEL: mod_sel_r <= wb_dat_i[7:0];
					dsss_hdr_pkg::OFF_SERVICE: service_r <= wb_dat_i[7:0];
					dsss_hdr_pkg::OFF_TX_LENGTH: length_r[7:0] <= wb_dat_i[7:0];
					dsss_hdr_pkg::OFF_SCR_TAPS: taps_r <= wb_dat_i[6:0];
					default: ;
				endcase
			if (wb_sel_i[1] && adr == dsss_hdr_pkg::OFF_TX_LENGTH)
				length_r[15:8] <= wb_dat_i[15:8];
		end
	end

	// transmit state
	tx_state_e tx_st_r;
	logic [6:0] div_r;
	logic [7:0] cnt_r;
	logic [47:0] hdr_r;
	logic [6:0] scr_r;
	logic [1:0] ph_r;
	logic [2:0] mode_r;
	logic [7:0] byte_r;
	logic [2:0] bitpos_r;
	logic last_r, odd_r, pe_d_r;
	logic tick, is_data, hi_rate, need_byte, data_empty, byte_done;
	logic crc_end, tx_crc_bit;
	logic [3:0] nbits;
	logic [3:0] pos_sum;
	logic [7:0] raw;
	logic [14:0] scr_res;
	logic [7:0] sb;
	logic [15:0] chip_nxt;
	logic [1:0] ph_nxt;

	assign tick = (div_r == 7'h00) && tx_st_r != TX_IDLE;
	assign is_data = tx_st_r == TX_DATA || tx_st_r == TX_TAIL;
	assign crc_end = tx_st_r == TX_CRC && cnt_r == 8'(dsss_hdr_pkg::CRC_BITS - 1);
	assign hi_rate = mode_r[1] && (is_data || crc_end);
	assign need_byte = bitpos_r == 3'h0;
	assign data_empty = need_byte & ~tx_data_valid;
	assign tx_data_ready = tick && tx_st_r == TX_DATA && need_byte;
	assign nbits = !is_data ? 4'h1 : mode_r[1] ? (mode_r[0] ? 4'h8 : 4'h4) :
		(mode_r[0] ? 4'h2 : 4'h1);
	assign pos_sum = {1'b0, bitpos_r} + nbits;
	assign byte_done = pos_sum[3];
	assign tx_busy = tx_st_r != TX_IDLE;
	assign data_portion = is_data;

	// bit source per state; every bit, payload included, then goes through the scrambler
	assign raw = tx_st_r == TX_PRE ? 8'h01 :
		tx_st_r == TX_HDR ? {7'h00, hdr_r[0]} :
		tx_st_r == TX_CRC ? {7'h00, tx_crc_bit} :
		tx_st_r == TX_DATA && !data_empty ?
		(need_byte ? tx_data : byte_r >> bitpos_r) : 8'h00;
	assign scr_res = scramble(raw, nbits, scr_r, taps_r);
	assign sb = scr_res[7:0];

	// symbol mapper
	always_comb
	begin
		logic [1:0] p1, p2, p3, p4, iq;
		logic [7:0] c1, c2;
		p1 = 2'h0;
		p2 = 2'h0;
		p3 = 2'h0;
		p4 = 2'h0;
		iq = 2'h0;
		c1 = dsss_hdr_pkg::MWALSH[8 * sb[2:0] +: 8] ^ {8{sb[3]}};
		c2 = dsss_hdr_pkg::MWALSH[8 * sb[6:4] +: 8] ^ {8{sb[7]}};
		ph_nxt = ph_r;
		chip_nxt = 16'h0000;
		if (!is_data || mode_r[1:0] == dsss_hdr_pkg::MOD_DBPSK)
		begin
			ph_nxt = ph_r + {sb[0], 1'b0};
			chip_nxt = {8{ph_nxt}};
		end
		else if (mode_r[1:0] == dsss_hdr_pkg::MOD_DQPSK)
		begin
			ph_nxt = ph_r + {sb[0], sb[0] ^ sb[1]};
			chip_nxt = {8{ph_nxt}};
		end
		else if (mode_r[dsss_hdr_pkg::MOD_CCK_BIT])
		begin
			// odd symbols get an extra half turn on the common phase
			p1 = ph_r + {sb[0], sb[0] ^ sb[1]} + {odd_r, 1'b0};
			if (mode_r[0])
			begin
				p2 = {sb[2], sb[3]};
				p3 = {sb[4], sb[5]};
				p4 = {sb[6], sb[7]};
			end
			else
			begin
				p2 = {sb[2], 1'b1};
				p4 = {sb[3], 1'b0};
			end
			ph_nxt = p1;
			chip_nxt = {p1, p1 + p2 + 2'h2, p1 + p3, p1 + p2 + p3,
				p1 + p4 + 2'h2, p1 + p2 + p4, p1 + p3 + p4, p1 + p2 + p3 + p4};
		end
		else
		begin
			for (int k = 0; k < 8; k++)
			begin
				if (mode_r[0])
					iq = {c2[k], c2[k] ^ c1[k]};
				else
					iq = {c1[k], 1'b0};
				chip_nxt[2 * k +: 2] = iq + ph_r;
			end
		end
	end

	// transmit sequencer
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			tx_st_r <= TX_IDLE;
			div_r <= 7'h00;
			cnt_r <= 8'h00;
			hdr_r <= 48'h0;
			scr_r <= dsss_hdr_pkg::SCR_SEED;
			ph_r <= 2'h0;
			mode_r <= 3'h0;
			byte_r <= 8'h00;
			bitpos_r <= 3'h0;
			last_r <= 1'b0;
			odd_r <= 1'b0;
			pe_d_r <= 1'b0;
			underrun_r <= 1'b0;
			sym_strobe <= 1'b0;
			chip_phase <= 16'h0000;
		end
		else
		begin
			pe_d_r <= transmit_power_enable;
			sym_strobe <= tick;
			if (tick)
			begin
				chip_phase <= chip_nxt;
				ph_r <= ph_nxt;
				scr_r <= scr_res[14:8];
				div_r <= 7'(hi_rate ? dsss_hdr_pkg::SYM_HI_CYC - 1 :
					dsss_hdr_pkg::SYM_LO_CYC - 1);
			end
			else if (div_r != 7'h00)
				div_r <= div_r - 7'h01;
			if (!transmit_power_enable)
				tx_st_r <= TX_IDLE;
			else
				case (tx_st_r)
					TX_IDLE:
						if (!pe_d_r)
						begin
							tx_st_r <= pre_len_r == 8'h00 ? TX_HDR : TX_PRE;
							hdr_r <= {length_r, service_r,
								sig_for(mod_sel_r[1:0], sig_codes_r),
								dsss_hdr_pkg::SFD_VALUE};
							mode_r <= mod_sel_r[2:0];
							scr_r <= dsss_hdr_pkg::SCR_SEED;
							ph_r <= 2'h0;
							cnt_r <= 8'h00;
							underrun_r <= 1'b0;
							div_r <= 7'(dsss_hdr_pkg::SYM_LO_CYC - 1);
						end
					TX_PRE:
						if (tick)
						begin
							cnt_r <= cnt_r + 8'h01;
							if (cnt_r == pre_len_r - 8'h01)
							begin
								tx_st_r <= TX_HDR;
								cnt_r <= 8'h00;
							end
						end
					TX_HDR:
						if (tick)
						begin
							hdr_r <= hdr_r >> 1;
							cnt_r <= cnt_r + 8'h01;
							if (cnt_r == 8'(dsss_hdr_pkg::HDR_BITS - 1))
							begin
								tx_st_r <= TX_CRC;
								cnt_r <= 8'h00;
							end
						end
					TX_CRC:
						if (tick)
						begin
							cnt_r <= cnt_r + 8'h01;
							if (crc_end)
							begin
								tx_st_r <= TX_DATA;
								bitpos_r <= 3'h0;
								odd_r <= 1'b0;
							end
						end
					TX_DATA:
						if (tick)
						begin
							odd_r <= ~odd_r;
							if (data_empty)
							begin
								underrun_r <= 1'b1;
								tx_st_r <= TX_TAIL;
								cnt_r <= 8'h01;
							end
							else
							begin
								if (need_byte)
								begin
									byte_r <= tx_data;
									last_r <= tx_data_last;
								end
								bitpos_r <= pos_sum[2:0];
								if (byte_done && (need_byte ? tx_data_last : last_r))
								begin
									tx_st_r <= TX_TAIL;
									cnt_r <= 8'h00;
								end
							end
						end
					TX_TAIL:
						if (tick)
						begin
							odd_r <= ~odd_r;
							cnt_r <= cnt_r + 8'h01;
							if (cnt_r >= 8'(TAIL_SYMS - 1))
								tx_st_r <= TX_DONE;
						end
					TX_DONE: ; // waits for the mac to drop power
					default: tx_st_r <= TX_IDLE;
				endcase
		end
	end

	crc16_serial tx_crc (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.init(tx_st_r == TX_IDLE),
		.en(tick && tx_st_r == TX_HDR &&
			cnt_r >= 8'(dsss_hdr_pkg::SFD_BITS)),
		.shift_out(tick && tx_st_r == TX_CRC),
		.bit_in(hdr_r[0]),
		.out_bit(tx_crc_bit),
		.crc()
	);

	// receive header checks
	rx_state_e rx_st_r;
	logic [6:0] us_r;
	logic [7:0] timer_r;
	logic [5:0] rcnt_r;
	logic [15:0] sfd_sh_r;
	logic [31:0] fld_r;
	logic [15:0] rcrc_r;
	logic [15:0] rx_crc;
	logic [15:0] sfd_next;
	logic [3:0] sig_hit;
	logic [1:0] hit_rate;
	logic rx_active, us_tick, crc_ok, sfd_hit;

	assign rx_active = receive_power_enable & rx_pn_acquired;
	assign us_tick = us_r == 7'(dsss_hdr_pkg::US_CYC - 1);
	assign sfd_next = {rx_bit, sfd_sh_r[15:1]};
	assign sfd_hit = rx_bit_valid && sfd_next == dsss_hdr_pkg::SFD_VALUE;
	assign crc_ok = ~rx_crc == {rcrc_r[14:0], rx_bit};

	// compare the received signal field with each code
	for (genvar g = 0; g < 4; g++)
	begin : g_sig
		assign sig_hit[g] = fld_r[7:0] == sig_for(2'(g), sig_codes_r);
	end
	assign hit_rate = sig_hit[0] ? 2'h0 : sig_hit[1] ? 2'h1 :
		sig_hit[2] ? 2'h2 : 2'h3;

	// receive sequencer; status cleared at each new acquisition
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			rx_st_r <= RX_IDLE;
			us_r <= 7'h00;
			timer_r <= 8'h00;
			rcnt_r <= 6'h00;
			sfd_sh_r <= 16'h0000;
			fld_r <= 32'h0;
			rcrc_r <= 16'h0000;
			rx_status_r <= 8'h00;
			rx_reacquire <= 1'b0;
			demod_data_valid <= 1'b0;
			rx_rate_switch <= 1'b0;
			rx_rate <= 2'h0;
			rx_length <= 16'h0000;
		end
		else
		begin
			us_r <= us_tick ? 7'h00 : us_r + 7'h01;
			rx_reacquire <= 1'b0;
			if (!rx_active)
			begin
				rx_st_r <= RX_IDLE;
				demod_data_valid <= 1'b0;
				rx_rate_switch <= 1'b0;
			end
			else
				case (rx_st_r)
					RX_IDLE:
					begin
						rx_st_r <= RX_SEARCH;
						timer_r <= 8'h00;
						sfd_sh_r <= 16'h0000;
						rx_status_r <= 8'h00;
						rx_rate_switch <= 1'b0;
					end
					RX_SEARCH:
						if (sfd_hit)
						begin
							rx_st_r <= RX_HDR;
							rcnt_r <= 6'h00;
							rx_status_r[dsss_hdr_pkg::RXS_SFD] <= 1'b1;
						end
						else
						begin
							if (rx_bit_valid)
								sfd_sh_r <= sfd_next;
							if (us_tick)
								timer_r <= timer_r + 8'h01;
							if (timer_r >= timeout_r)
							begin
								rx_st_r <= RX_LOST;
								rx_reacquire <= 1'b1;
								rx_status_r[dsss_hdr_pkg::RXS_TIMEOUT] <= 1'b1;
							end
						end
					RX_HDR:
						if (rx_bit_valid)
						begin
							rcnt_r <= rcnt_r + 6'h01;
							if (rcnt_r < 6'(dsss_hdr_pkg::FIELD_BITS))
								fld_r <= {rx_bit, fld_r[31:1]};
							else
								rcrc_r <= {rcrc_r[14:0], rx_bit};
							if (rcnt_r == 6'(dsss_hdr_pkg::HDR_BITS - 1))
							begin
								rx_status_r[dsss_hdr_pkg::RXS_RATE_LSB +: 2] <= hit_rate;
								if (!crc_ok)
								begin
									rx_st_r <= RX_LOST;
									rx_status_r[dsss_hdr_pkg::RXS_CRC_ERR] <= 1'b1;
									demod_data_valid <= 1'b0;
								end
								else if (sig_hit == 4'h0)
								begin
									rx_st_r <= RX_LOST;
									rx_status_r[dsss_hdr_pkg::RXS_SIG_BAD] <= 1'b1;
								end
								else
								begin
									rx_st_r <= RX_DATA;
									demod_data_valid <= 1'b1;
									rx_rate <= hit_rate;
									rx_rate_switch <= hit_rate != 2'h0;
									rx_length <= fld_r[31:16];
								end
							end
						end
					RX_DATA: ;
					RX_LOST: ;
					default: rx_st_r <= RX_IDLE;
				endcase
		end
	end

	crc16_serial rx_crc_eng (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.init(rx_st_r != RX_HDR),
		.en(rx_bit_valid && rx_st_r == RX_HDR &&
			rcnt_r < 6'(dsss_hdr_pkg::FIELD_BITS)),
		.shift_out(1'b0),
		.bit_in(rx_bit),
		.out_bit(),
		.crc(rx_crc)
	);
endmodule

// *** bench/framer_checker.sv ***
`timescale 1ns/100ps
module framer_checker #(
	parameter int TAIL_SYMS = 3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// transmit side
	input wire logic transmit_power_enable,
	input wire logic tx_data_ready,
	input wire logic sym_strobe,
	input wire logic data_portion,
	input wire logic tx_busy,
	// receive side
	input wire logic receive_power_enable,
	input wire logic rx_bit_valid,
	input wire logic rx_reacquire,
	input wire logic demod_data_valid,
	input wire logic rx_rate_switch,
	input wire logic [1:0] rx_rate
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// bus answers after exactly one wait, and only once
	a_ack_wait: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o) else $error("ack held");
	// symbols are never closer than nine cycles apart
	a_strobe_gap: assert property (
		sym_strobe |=> !sym_strobe [*8]) else $error("symbols too close");
	a_first_symbol: assert property (
		$rose(transmit_power_enable) && !tx_busy |-> ##[99:102] sym_strobe)
		else $error("first symbol late");
	a_data_busy: assert property (
		data_portion |-> tx_busy) else $error("data outside frame");
	a_power_off: assert property (
		!transmit_power_enable |-> ##[0:2] !tx_busy) else $error("still busy");
	a_ready_pulse: assert property (
		tx_data_ready |=> !tx_data_ready) else $error("ready held");
	// receive results drop with the receiver and follow real bits
	a_rx_clear: assert property (
		!receive_power_enable |=> !demod_data_valid && !rx_rate_switch)
		else $error("rx valid while off");
	a_valid_cause: assert property (
		$rose(demod_data_valid) |-> $past(rx_bit_valid) || $past(rx_bit_valid, 2))
		else $error("valid without bits");
	a_rate_switch: assert property (
		demod_data_valid |-> rx_rate_switch == (rx_rate != 2'h0))
		else $error("rate switch wrong");
	a_reacq_pulse: assert property (
		rx_reacquire |-> !demod_data_valid ##1 !rx_reacquire)
		else $error("reacquire wrong");

	c_frame: cover property ($rose(transmit_power_enable));
	c_data: cover property (sym_strobe && data_portion);
	c_hdr_ok: cover property ($rose(demod_data_valid));
	c_reacq: cover property (rx_reacquire);
endmodule

bind dsss_phy_header_framer framer_checker #(.TAIL_SYMS(TAIL_SYMS)) chk_i (
	.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.transmit_power_enable, .tx_data_ready, .sym_strobe, .data_portion,
	.tx_busy, .receive_power_enable, .rx_bit_valid, .rx_reacquire,
	.demod_data_valid, .rx_rate_switch, .rx_rate
);

// *** bench/mac_model.sv ***
`timescale 1ns/100ps
module mac_model (
	// clock and start request
	input wire logic ref_clk,
	input wire logic go,
	// framer handshake
	input wire logic tx_data_ready,
	input wire logic data_portion,
	output logic transmit_power_enable,
	output logic [7:0] tx_data,
	output logic tx_data_valid,
	output logic tx_data_last
);
	logic [1:0] idx;
	logic seen;

	initial
	begin
		transmit_power_enable = 0;
		idx = 0;
		seen = 0;
	end

	// two payload bytes; once used up valid drops and the byte lane holds C3
	assign tx_data_valid = transmit_power_enable && idx < 2;
	assign tx_data = idx[0] ? 8'h5A : 8'hC3;
	assign tx_data_last = idx == 1;

	// power drops once the tail symbols are out; a start wins over it
	always @(posedge ref_clk)
	begin
		if (tx_data_ready && tx_data_valid)
			idx <= idx + 1;
		if (data_portion)
			seen <= 1;
		if (seen && !data_portion)
			transmit_power_enable <= 0;
		if (go && !transmit_power_enable)
		begin
			transmit_power_enable <= 1;
			idx <= 0;
			seen <= 0;
		end
	end
endmodule

// *** bench/tb_dsss_phy_header_framer.sv ***
`timescale 1ns/100ps
module tb_dsss_phy_header_framer;
	logic ref_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, go;
	logic [7:0] wb_adr_i, tx_data;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rdat;
	logic transmit_power_enable, tx_data_valid, tx_data_last, tx_data_ready;
	logic sym_strobe, data_portion, tx_busy, rx_reacquire, demod_data_valid;
	logic receive_power_enable, rx_pn_acquired, rx_bit, rx_bit_valid;
	logic rx_rate_switch, ph1, mixed;
	logic [1:0] rx_rate;
	logic [15:0] chip_phase, rx_length;
	logic bits [0:127];
	int bad_count = 0, tests_run = 0, cyc_n = 0, nsym, gap, last_t;

	dsss_phy_header_framer dsss_phy_header_framer_i (.ref_clk, .rst_b,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .transmit_power_enable, .tx_data,
		.tx_data_valid, .tx_data_last, .tx_data_ready, .sym_strobe,
		.chip_phase, .data_portion, .tx_busy, .receive_power_enable,
		.rx_pn_acquired, .rx_bit, .rx_bit_valid, .rx_reacquire,
		.demod_data_valid, .rx_rate_switch, .rx_rate, .rx_length);
	mac_model mac_model_i (.ref_clk, .go, .tx_data_ready, .data_portion,
		.transmit_power_enable, .tx_data, .tx_data_valid, .tx_data_last);

	initial
	begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one classic cycle; waits for ack, never assumes its latency
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
		begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rdat = wb_dat_o;
		if (n >= 50)
			bad_count++;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask

	// header bits in send order: fields lsb first, inverted check msb first
	function automatic logic [47:0] hdr(input logic [7:0] s, input logic [7:0] v,
		input logic [15:0] l);
		logic [47:0] h;
		logic [15:0] c;
		logic f;
		h = {16'h0000, l, v, s};
		c = 16'hFFFF;
		for (int i = 0; i < 32; i++)
		begin
			f = h[i] ^ c[15];
			c = {c[14:0], 1'b0} ^ (f ? 16'h1021 : 16'h0000);
		end
		for (int i = 0; i < 16; i++)
			h[32 + i] = ~c[15 - i];
		return h;
	endfunction

	// decode each symbol as a phase change against the one before
	always @(posedge ref_clk)
	begin
		cyc_n <= cyc_n + 1;
		if (cyc_n > 90000)
		begin
			bad_count++;
			conclude;
		end
		if (sym_strobe === 1'b1 && nsym < 128)
		begin
			bits[nsym] = chip_phase[1] ^ ph1;
			ph1 = chip_phase[1];
			if (nsym < 72 && chip_phase !== {8{chip_phase[1:0]}})
				mixed = 1;
			gap = cyc_n - last_t;
			last_t = cyc_n;
			nsym++;
		end
	end

	task automatic t_regs;
		logic [7:0] rv [11];
		rv = '{8'h80, 8'h40, 8'h0A, 8'h14, 8'h37, 8'h6E, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h48};
		for (int i = 0; i < 11; i++)
		begin
			wb(0, 8'(4 * i), 32'h0);
			check(rdat, rv[i]);
		end
		wb(1, dsss_hdr_pkg::OFF_TX_LENGTH, 32'hBEEF);
		wb(0, dsss_hdr_pkg::OFF_TX_LENGTH, 32'h0);
		check(rdat, 16'hBEEF);
		wb(1, dsss_hdr_pkg::OFF_RX_STATUS, 32'hFF);
		wb(0, dsss_hdr_pkg::OFF_RX_STATUS, 32'h0);
		check(rdat, 8'h00);
		wb(1, 8'h30, 32'h5A);
		wb(0, 8'h30, 32'h0);
		check(rdat, 8'h00);
	endtask

	task automatic t_timeout;
		int n;
		n = 0;
		wb(1, dsss_hdr_pkg::OFF_SEARCH_TIMEOUT, 32'h2);
		receive_power_enable <= 1;
		rx_pn_acquired <= 1;
		do
		begin
			@(posedge ref_clk);
			n++;
		end while (rx_reacquire !== 1'b1 && n < 1000);
		check(n > 100 && n <= 203, 1);
		rx_pn_acquired <= 0;
		receive_power_enable <= 0;
		wb(0, dsss_hdr_pkg::OFF_RX_STATUS, 32'h0);
		check(rdat[1], 1);
	endtask

	// preamble ones, delimiter, then header with a good or broken check
	task automatic t_rx(input logic bad);
		logic [47:0] h;
		h = hdr(8'h6E, 8'h00, 16'h0BAD);
		h[47] = h[47] ^ bad;
		@(posedge ref_clk);
		receive_power_enable <= 1;
		rx_pn_acquired <= 1;
		for (int i = 0; i < 72; i++)
		begin
			@(posedge ref_clk);
			rx_bit_valid <= 1;
			rx_bit <= i < 8 ? 1'b1 : i < 24 ? dsss_hdr_pkg::SFD_VALUE[i - 8] :
				h[i - 24];
		end
		@(posedge ref_clk);
		rx_bit_valid <= 0;
		repeat (2) @(posedge ref_clk);
		check(demod_data_valid, !bad);
		if (!bad)
			check({rx_rate_switch, rx_rate, rx_length}, 19'h70BAD);
		wb(0, dsss_hdr_pkg::OFF_RX_STATUS, 32'h0);
		check({rdat[7:6], rdat[2]}, {2'h3, bad});
		receive_power_enable <= 0;
		rx_pn_acquired <= 0;
	endtask

	// one frame, scrambled with taps tp, decoded symbol by symbol
	task automatic t_tx(input logic [2:0] m, input logic [6:0] tp);
		int n;
		logic [63:0] g;
		logic [6:0] s;
		logic f;
		wb(1, dsss_hdr_pkg::OFF_TX_MOD_SEL, 32'(m));
		nsym = 0;
		mixed = 0;
		ph1 = 0;
		go <= 1;
		@(posedge ref_clk);
		go <= 0;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end while ((transmit_power_enable || tx_busy) !== 1'b0 && n < 12000);
		// undo the self-synchronising scrambler; zero taps leave bits alone
		s = dsss_hdr_pkg::SCR_SEED;
		for (int i = 0; i < 88; i++)
		begin
			f = bits[i];
			bits[i] = f ^ (^(s & tp));
			s = {s[5:0], f};
		end
		g = 0;
		for (int i = 0; i < 7; i++)
			g[i] = bits[1 + i];
		check(g, 64'h7F);
		for (int i = 0; i < 64; i++)
			g[i] = bits[8 + i];
		check(g, {hdr(dsss_hdr_pkg::RST_SIG_CODES[8 * m[1:0] +: 8], 8'h80,
			16'h1234), dsss_hdr_pkg::SFD_VALUE});
		check(mixed, 0);
		check(nsym, 75 + 16 / (1 << m[1:0]));
		check(gap, m[1] ? dsss_hdr_pkg::SYM_HI_CYC : dsss_hdr_pkg::SYM_LO_CYC);
		for (int i = 0; i < 16; i++)
			g[i] = bits[72 + i];
		if (m == 0)
			check(g[15:0], 16'h5AC3);
		wb(0, dsss_hdr_pkg::OFF_TX_STATUS, 32'h0);
		check(rdat[1:0], 2'h0);
	endtask

	initial
	begin
		rst_b = 0;
		go = 0;
		wb_cyc_i = 0;
		wb_stb_i = 0;
		wb_we_i = 0;
		wb_adr_i = 0;
		wb_sel_i = 4'hF;
		wb_dat_i = 0;
		receive_power_enable = 0;
		rx_pn_acquired = 0;
		rx_bit = 0;
		rx_bit_valid = 0;
		repeat (12) @(posedge ref_clk);
		rst_b <= 1;
		t_regs;
		t_timeout;
		t_rx(0);
		t_rx(1);
		wb(1, dsss_hdr_pkg::OFF_PREAMBLE_LENGTH, 32'h8);
		wb(1, dsss_hdr_pkg::OFF_SCR_TAPS, 32'h0);
		wb(1, dsss_hdr_pkg::OFF_SERVICE, 32'h80);
		wb(1, dsss_hdr_pkg::OFF_TX_LENGTH, 32'h1234);
		for (int m = 0; m < 6; m++)
			t_tx(m == 4 ? 3'h6 : m == 5 ? 3'h7 : 3'(m), 7'h00);
		wb(1, dsss_hdr_pkg::OFF_SCR_TAPS, 32'(dsss_hdr_pkg::RST_SCR_TAPS));
		t_tx(3'h0, dsss_hdr_pkg::RST_SCR_TAPS);
		conclude;
	end
endmodule
